/* File: rtl/fpd_pkg.sv */
package fpd_pkg;
    // Register word indices on the serial register port
    localparam logic [7:0] ADDR_CONV_GLOBAL = 8'h01;
    localparam logic [7:0] ADDR_CONV_DIG_A  = 8'h04;
    localparam logic [7:0] ADDR_CONV_CH_A   = 8'h18;
    localparam logic [7:0] ADDR_CONV_CH_B   = 8'h24;
    localparam logic [7:0] ADDR_CONV_CH_C   = 8'h30;
    localparam logic [7:0] ADDR_CONV_CH_D   = 8'h3c;
    localparam logic [7:0] ADDR_AMP_CTRL    = 8'hc5;
    localparam logic [7:0] ADDR_AMP_CH_UP   = 8'hd5;
    // Field positions
    localparam int BIT_AMP_GLOBAL  = 15;
    localparam int BIT_AMP_QUICK   = 14;
    localparam int BIT_PREAMP      = 13;
    localparam int BIT_GAIN_CHAIN  = 12;
    localparam int BIT_CONV_GLOBAL = 0;
    localparam int BIT_SER_DIS     = 5;
    localparam int LSB_ANA         = 4;
    localparam int LSB_LANE        = 8;
    localparam int LSB_DIG         = 12;
    localparam int NUM_CH          = 16;
    localparam logic [15:0] REG_RESET = 16'h0000;

    typedef struct packed {
        logic [15:0] preamp;
        logic [15:0] gainChain;
        logic [15:0] mixer;
        logic [15:0] crossPoint;
        logic        reference;
        logic        controlVoltage;
        logic        cwSummer;
    } fpd_amp_pd_t;

    typedef struct packed {
        logic [15:0] analog;
        logic [15:0] digital;
        logic [15:0] dataSerializer;
        logic        frameClockSerializer;
        logic        refClockBuffer;
        logic        pll;
    } fpd_conv_pd_t;

    typedef struct packed {
        logic        write;
        logic [7:0]  addr;
        logic [15:0] data;
    } fpd_reg_req_t;
endpackage

/* File: rtl/fpd_sync.sv */
`timescale 1ns/1ps
module fpd_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Pin level
    input  wire logic pinIn,
    output logic      pinSync
);
    logic stage1_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stage1_r <= 1'b0;
            pinSync  <= 1'b0;
        end else begin
            stage1_r <= pinIn;
            pinSync  <= stage1_r;
        end
    end
endmodule // fpd_sync

/* File: rtl/fpd_regs.sv */
`timescale 1ns/1ps
module fpd_regs
    import fpd_pkg::*;
(
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rstn,
    // Register port
    input  fpd_pkg::fpd_reg_req_t req,
    input  wire logic          reqValid,
    output logic [15:0]        readData,
    output logic               readHit,
    // Stored words
    output logic [15:0]        convGlobal_r,
    output logic [15:0]        convDigA_r,
    output logic [15:0]        convCh_r [4],
    output logic [15:0]        ampCtrl_r,
    output logic [15:0]        ampChUp_r
);
    function automatic logic [2:0] chIndex(input logic [7:0] a);
        case (a)
            ADDR_CONV_CH_A: chIndex = 3'd0;
            ADDR_CONV_CH_B: chIndex = 3'd1;
            ADDR_CONV_CH_C: chIndex = 3'd2;
            ADDR_CONV_CH_D: chIndex = 3'd3;
            default:        chIndex = 3'd4;
        endcase
    endfunction

    logic [2:0] idx;
    assign idx = chIndex(req.addr);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            convGlobal_r <= REG_RESET;
            convDigA_r   <= REG_RESET;
            ampCtrl_r    <= REG_RESET;
            ampChUp_r    <= REG_RESET;
            for (int i = 0; i < 4; i++) begin
                convCh_r[i] <= REG_RESET;
            end
        end else if (reqValid && req.write) begin
            if (req.addr == ADDR_CONV_GLOBAL) convGlobal_r <= req.data;
            if (req.addr == ADDR_CONV_DIG_A)  convDigA_r   <= req.data;
            if (req.addr == ADDR_AMP_CTRL)    ampCtrl_r    <= req.data;
            if (req.addr == ADDR_AMP_CH_UP)   ampChUp_r    <= req.data;
            if (idx != 3'd4) convCh_r[idx[1:0]] <= req.data;
        end
    end

    // Unmapped words read as zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            readData <= 16'h0000;
            readHit  <= 1'b0;
        end else if (reqValid && !req.write) begin
            readHit  <= 1'b1;
            if (req.addr == ADDR_CONV_GLOBAL)    readData <= convGlobal_r;
            else if (req.addr == ADDR_CONV_DIG_A) readData <= convDigA_r;
            else if (req.addr == ADDR_AMP_CTRL)  readData <= ampCtrl_r;
            else if (req.addr == ADDR_AMP_CH_UP) readData <= ampChUp_r;
            else if (idx != 3'd4)                readData <= convCh_r[idx[1:0]];
            else begin
                readData <= 16'h0000;
                readHit  <= 1'b0;
            end
        end else begin
            readHit <= 1'b0;
        end
    end
endmodule // fpd_regs

/* File: rtl/fpd_frontend_powerdown_control.sv */
// Contract
// - Pins and serial-written register bits both request block power-down.
// - Band gap and serial interface never power down.
// - Amp global bit or global pin sleeps every amplifier-side block.
// - Amp quick bit or quick pin sleeps all but reference and control voltage.
// - Per-channel amp bits sleep that channel's preamp, gain chain, mixer, crosspoint.
// - Preamp bit sleeps only the preamps of all channels.
// - Gain chain bit sleeps only attenuator, PGA and LPF of all channels.
// - Each block enable is the OR of all controls covering it.
// - Converter global bit or global pin sleeps every converter block.
// - Quick pin sleeps converter analog, digital, data serializers only.
// - Serial-out disable bit sleeps data and frame/clock serializers.
// - Per-channel analog bits sleep only that channel's converter analog.
// - Per-channel digital bits sleep only that channel's converter digital.
// - Per-channel lane bits sleep only that channel's data serializer.
// - Per-channel controls hit one channel; global controls hit all.
`timescale 1ns/1ps
module fpd_frontend_powerdown_control
    import fpd_pkg::*;
(
    // Clock and reset
    input  wire logic           clock,
    input  wire logic           rstn,
    // Sleep pins
    input  wire logic           global_sleep_pin,
    input  wire logic           quick_sleep_pin,
    // Register port
    input  fpd_pkg::fpd_reg_req_t regReq,
    input  wire logic           regReqValid,
    output logic [15:0]         regReadData,
    output logic                regReadValid,
    // Block sleep enables
    output fpd_pkg::fpd_amp_pd_t  ampSleep,
    output fpd_pkg::fpd_conv_pd_t convSleep,
    // Always-on domain indicators
    output logic                bandGapOn,
    output logic                serialIfOn
);
    import fpd_pkg::*;

    logic        globalPin;
    logic        quickPin;
    logic [15:0] convGlobal_r;
    logic [15:0] convDigA_r;
    logic [15:0] convCh_r [4];
    logic [15:0] ampCtrl_r;
    logic [15:0] ampChUp_r;

    fpd_sync uGlobalSync (
        .clock   (clock),
        .rstn    (rstn),
        .pinIn   (global_sleep_pin),
        .pinSync (globalPin)
    );

    fpd_sync uQuickSync (
        .clock   (clock),
        .rstn    (rstn),
        .pinIn   (quick_sleep_pin),
        .pinSync (quickPin)
    );

    // Register port never gated by any sleep control
    fpd_regs uRegs (
        .clock        (clock),
        .rstn         (rstn),
        .req          (regReq),
        .reqValid     (regReqValid),
        .readData     (regReadData),
        .readHit      (regReadValid),
        .convGlobal_r (convGlobal_r),
        .convDigA_r   (convDigA_r),
        .convCh_r     (convCh_r),
        .ampCtrl_r    (ampCtrl_r),
        .ampChUp_r    (ampChUp_r)
    );

    assign bandGapOn  = 1'b1;
    assign serialIfOn = 1'b1;

    // Field extraction
    logic        ampGlobal;
    logic        ampQuick;
    logic        preampAll;
    logic        gainAll;
    logic [15:0] ampChan;
    logic        convGlobal;
    logic        serDisable;
    logic [15:0] anaChan;
    logic [15:0] digChan;
    logic [15:0] laneChan;

    function automatic logic [15:0] spread(input logic b);
        spread = {NUM_CH{b}};
    endfunction

    assign ampGlobal  = ampCtrl_r[BIT_AMP_GLOBAL] | globalPin;
    assign ampQuick   = ampCtrl_r[BIT_AMP_QUICK] | quickPin;
    assign preampAll  = ampCtrl_r[BIT_PREAMP];
    assign gainAll    = ampCtrl_r[BIT_GAIN_CHAIN];
    assign ampChan    = {ampChUp_r[7:0], ampCtrl_r[7:0]};
    assign convGlobal = convGlobal_r[BIT_CONV_GLOBAL] | globalPin;
    assign serDisable = convGlobal_r[BIT_SER_DIS];

    // Channel order: register A holds channels 3..0, D holds 15..12
    always_comb begin
        anaChan  = '0;
        digChan  = '0;
        laneChan = '0;
        for (int g = 0; g < 4; g++) begin
            anaChan[g*4 +: 4]  = convCh_r[g][LSB_ANA +: 4];
            laneChan[g*4 +: 4] = convCh_r[g][LSB_LANE +: 4];
            if (g == 0) begin
                digChan[3:0] = convDigA_r[LSB_DIG +: 4];
            end else begin
                digChan[g*4 +: 4] = convCh_r[g][LSB_DIG +: 4];
            end
        end
    end

    // Combinational OR of every covering control; releases wake immediately
    logic [15:0] allChAmp;
    assign allChAmp = spread(ampGlobal | ampQuick);

    assign ampSleep.preamp         = allChAmp | spread(preampAll) | ampChan;
    assign ampSleep.gainChain      = allChAmp | spread(gainAll) | ampChan;
    assign ampSleep.mixer          = allChAmp | ampChan;
    assign ampSleep.crossPoint     = allChAmp | ampChan;
    assign ampSleep.reference      = ampGlobal;
    assign ampSleep.controlVoltage = ampGlobal;
    assign ampSleep.cwSummer       = ampGlobal | ampQuick;

    assign convSleep.analog         = spread(convGlobal | quickPin) | anaChan;
    assign convSleep.digital        = spread(convGlobal | quickPin) | digChan;
    assign convSleep.dataSerializer = spread(convGlobal | quickPin | serDisable) | laneChan;
    assign convSleep.frameClockSerializer = convGlobal | serDisable;
    assign convSleep.refClockBuffer = convGlobal;
    assign convSleep.pll            = convGlobal;

    a_global_amp_off: assert property (@(posedge clock) disable iff (!rstn)
        ampCtrl_r[BIT_AMP_GLOBAL] |-> (ampSleep.reference && &ampSleep.preamp
        && ampSleep.cwSummer))
        else $error("amp global bit did not sleep all amp blocks");

    a_quick_keeps_ref: assert property (@(posedge clock) disable iff (!rstn)
        (ampQuick && !ampGlobal) |-> (!ampSleep.reference && &ampSleep.mixer))
        else $error("quick sleep wrong on amp side");

    a_chan_amp_one: assert property (@(posedge clock) disable iff (!rstn)
        (!ampGlobal && !ampQuick && !gainAll) |-> (ampSleep.gainChain == ampChan))
        else $error("per-channel amp sleep mismatched");

    // Checked against the raw words so a wrong channel order shows up here
    a_amp_chan_map: assert property (@(posedge clock) disable iff (!rstn)
        (!ampGlobal && !ampQuick) |-> (ampSleep.mixer == {ampChUp_r[7:0], ampCtrl_r[7:0]}
        && ampSleep.crossPoint == ampSleep.mixer))
        else $error("amp channel mapping wrong");

    a_preamp_only: assert property (@(posedge clock) disable iff (!rstn)
        (preampAll && !ampGlobal && !ampQuick && ampChan == 16'h0000)
        |-> (ampSleep.mixer == 16'h0000 && &ampSleep.preamp))
        else $error("preamp bit leaked to other blocks");

    a_gain_only: assert property (@(posedge clock) disable iff (!rstn)
        (gainAll && !preampAll && !ampGlobal && !ampQuick && ampChan == 16'h0000)
        |-> (ampSleep.preamp == 16'h0000 && &ampSleep.gainChain))
        else $error("gain chain bit leaked");

    a_global_pin_conv: assert property (@(posedge clock) disable iff (!rstn)
        $rose(globalPin) |-> (convSleep.pll && convSleep.refClockBuffer
        && &convSleep.analog))
        else $error("global pin did not sleep converter");

    a_conv_bit_all: assert property (@(posedge clock) disable iff (!rstn)
        convGlobal_r[BIT_CONV_GLOBAL] |-> (&convSleep.digital && &convSleep.dataSerializer
        && convSleep.frameClockSerializer && convSleep.refClockBuffer))
        else $error("converter global bit did not sleep all blocks");

    a_quick_conv: assert property (@(posedge clock) disable iff (!rstn)
        (quickPin && !convGlobal && !serDisable) |-> (!convSleep.frameClockSerializer
        && !convSleep.pll && &convSleep.dataSerializer))
        else $error("quick pin wrong on converter side");

    a_ser_disable: assert property (@(posedge clock) disable iff (!rstn)
        (serDisable && !convGlobal && !quickPin && anaChan == 16'h0000)
        |-> (convSleep.frameClockSerializer && convSleep.analog == 16'h0000))
        else $error("serial-out disable wrong");

    a_ser_keeps_core: assert property (@(posedge clock) disable iff (!rstn)
        (serDisable && !convGlobal && !quickPin) |-> (!convSleep.pll
        && !convSleep.refClockBuffer && convSleep.digital == digChan))
        else $error("serial-out disable reached converter core");

    a_chan_conv: assert property (@(posedge clock) disable iff (!rstn)
        (!convGlobal && !quickPin) |-> (convSleep.analog == anaChan
        && convSleep.digital == digChan))
        else $error("per-channel converter sleep mismatched");

    // Channels 3..0 of the digital field live in a different word than the others
    a_dig_group_zero: assert property (@(posedge clock) disable iff (!rstn)
        (!convGlobal && !quickPin) |-> (convSleep.digital[3:0] == convDigA_r[LSB_DIG +: 4]))
        else $error("digital group zero mapped wrong");

    a_lane_chan: assert property (@(posedge clock) disable iff (!rstn)
        (!convGlobal && !quickPin && !serDisable) |-> convSleep.dataSerializer == laneChan)
        else $error("lane sleep mismatched");

    a_wake_release: assert property (@(posedge clock) disable iff (!rstn)
        ($fell(globalPin) && ampCtrl_r == 16'h0000) |-> !ampSleep.reference)
        else $error("block did not wake on release");

    // A pin level held two samples reaches the outputs through the two sync stages
    sequence s_global_rise;
        $rose(global_sleep_pin) ##1 global_sleep_pin;
    endsequence

    sequence s_global_drop;
        $fell(global_sleep_pin) ##1 !global_sleep_pin;
    endsequence

    sequence s_quick_rise;
        $rose(quick_sleep_pin) ##1 quick_sleep_pin;
    endsequence

    a_global_pin_lat: assert property (@(posedge clock) disable iff (!rstn)
        s_global_rise |=> (ampSleep.reference && convSleep.pll))
        else $error("global pin sleep arrived late");

    a_quick_pin_lat: assert property (@(posedge clock) disable iff (!rstn)
        s_quick_rise |=> (&convSleep.analog && ampSleep.cwSummer))
        else $error("quick pin sleep arrived late");

    a_wake_latency: assert property (@(posedge clock) disable iff (!rstn)
        s_global_drop |=> (ampSleep.reference == ampCtrl_r[BIT_AMP_GLOBAL]
        && convSleep.pll == convGlobal_r[BIT_CONV_GLOBAL]))
        else $error("global pin release did not wake blocks");

    a_always_on: assert property (@(posedge clock) disable iff (!rstn)
        bandGapOn && serialIfOn)
        else $error("always-on domain dropped");
endmodule // fpd_frontend_powerdown_control

/* File: test/fpd_host_model.sv */
`timescale 1ns/1ps
module fpd_host_model
    import fpd_pkg::*;
(
    // Clock
    input  wire logic             clock,
    // Requests toward the device
    output fpd_pkg::fpd_reg_req_t req,
    output logic                  reqValid,
    output logic                  gPin,
    output logic                  qPin
);
    initial begin
        req = '0;
        reqValid = 1'b0;
        gPin = 1'b0;
        qPin = 1'b0;
    end

    // One-cycle request; a released bus shows the inverse, never a stale copy
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge clock);
        req = '{write: w, addr: a, data: d};
        reqValid = 1'b1;
        @(negedge clock);
        reqValid = 1'b0;
        req = '{write: ~w, addr: ~a, data: ~d};
    endtask

    task automatic pins(input logic g, input logic q);
        @(negedge clock);
        gPin = g;
        qPin = q;
    endtask
endmodule // fpd_host_model

/* File: test/test_frontend_powerdown_control.sv */
`timescale 1ns/1ps
module test_frontend_powerdown_control;
    import fpd_pkg::*;
    logic         clock;
    logic         rstn;
    fpd_reg_req_t regReq;
    logic         regReqValid;
    logic         gPin;
    logic         qPin;
    logic [15:0]  regReadData;
    logic         regReadValid;
    logic         bandGapOn;
    logic         serialIfOn;
    fpd_amp_pd_t  ampSleep;
    fpd_conv_pd_t convSleep;
    logic [15:0]  shadow [8];
    int           mismatches;
    int           nCompared;
    int           seed;
    localparam logic [7:0] ADDRS [8] = '{ADDR_CONV_GLOBAL, ADDR_CONV_DIG_A, ADDR_CONV_CH_A,
        ADDR_CONV_CH_B, ADDR_CONV_CH_C, ADDR_CONV_CH_D, ADDR_AMP_CTRL, ADDR_AMP_CH_UP};

    fpd_host_model host (.clock(clock), .req(regReq), .reqValid(regReqValid),
        .gPin(gPin), .qPin(qPin));
    fpd_frontend_powerdown_control uut (.clock(clock), .rstn(rstn),
        .global_sleep_pin(gPin), .quick_sleep_pin(qPin), .regReq(regReq),
        .regReqValid(regReqValid), .regReadData(regReadData),
        .regReadValid(regReadValid), .ampSleep(ampSleep), .convSleep(convSleep),
        .bandGapOn(bandGapOn), .serialIfOn(serialIfOn));

    function automatic fpd_amp_pd_t expAmp(logic g, logic q);
        fpd_amp_pd_t e;
        logic ag;
        logic aq;
        logic c;
        ag = g | shadow[6][BIT_AMP_GLOBAL];
        aq = ag | q | shadow[6][BIT_AMP_QUICK];
        for (int i = 0; i < NUM_CH; i++) begin
            c = aq | (i < 8 ? shadow[6][i % 8] : shadow[7][i % 8]);
            e.preamp[i] = c | shadow[6][BIT_PREAMP];
            e.gainChain[i] = c | shadow[6][BIT_GAIN_CHAIN];
            e.mixer[i] = c;
            e.crossPoint[i] = c;
        end
        e.reference = ag;
        e.controlVoltage = ag;
        e.cwSummer = aq;
        return e;
    endfunction

    function automatic fpd_conv_pd_t expConv(logic g, logic q);
        fpd_conv_pd_t e;
        logic cg;
        logic dis;
        int k;
        int b;
        cg = g | shadow[0][BIT_CONV_GLOBAL];
        dis = shadow[0][BIT_SER_DIS];
        for (int i = 0; i < NUM_CH; i++) begin
            k = 2 + i / 4;
            b = i % 4;
            e.analog[i] = cg | q | shadow[k][LSB_ANA + b];
            e.digital[i] = cg | q | shadow[i < 4 ? 1 : k][LSB_DIG + b];
            e.dataSerializer[i] = cg | q | dis | shadow[k][LSB_LANE + b];
        end
        e.frameClockSerializer = cg | dis;
        e.refClockBuffer = cg;
        e.pll = cg;
        return e;
    endfunction

    task automatic chk(input string n, input logic [66:0] s, input logic [66:0] x);
        nCompared++;
        if (s !== x) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic final_report();
        if (mismatches == 0 && nCompared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic outs(input logic g, input logic q);
        chk("ampSleep", ampSleep, expAmp(g, q));
        chk("convSleep", convSleep, expConv(g, q));
        chk("alwaysOn", {bandGapOn, serialIfOn}, 2'b11);
    endtask

    task automatic step(input int r, input logic [15:0] d, input logic g, input logic q);
        host.access(1'b1, ADDRS[r], d);
        shadow[r] = d;
        host.pins(g, q);
        repeat (3) @(negedge clock);
        outs(g, q);
        host.access(1'b0, ADDRS[r], 16'h0000);
        chk("regReadValid", regReadValid, 1'b1);
        chk("regReadData", regReadData, d);
    endtask

    // Reset clears every word, so all blocks wake and reads return zero
    task automatic resetCheck();
        foreach (shadow[i]) shadow[i] = REG_RESET;
        outs(1'b0, 1'b0);
        for (int r = 0; r < 8; r++) begin
            host.access(1'b0, ADDRS[r], 16'h0000);
            chk("resetReadValid", regReadValid, 1'b1);
            chk("resetRead", regReadData, REG_RESET);
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        #200000;
        mismatches++;
        final_report();
    end

    initial begin
        rstn = 1'b0;
        mismatches = 0;
        nCompared = 0;
        seed = $urandom(32'hefca);
        repeat (5) @(posedge clock);
        @(negedge clock) rstn = 1'b1;
        resetCheck();
        // Walking one isolates each control; the next write releases it
        for (int r = 0; r < 8; r++) begin
            for (int b = 0; b < 16; b++) step(r, 16'h0001 << b, 1'b0, 1'b0);
            step(r, 16'h0000, 1'b0, 1'b0);
        end
        step(0, 16'h0000, 1'b1, 1'b0);
        step(0, 16'h0000, 1'b0, 1'b1);
        step(6, 16'h1000, 1'b0, 1'b1);
        step(0, 16'h0020, 1'b1, 1'b1);
        step(0, 16'h0000, 1'b0, 1'b0);
        repeat (200) begin
            step(int'($urandom % 8), 16'($urandom), 1'($urandom), 1'($urandom));
        end
        // Unmapped address: write ignored, read unanswered
        host.access(1'b1, 8'h02, 16'hffff);
        repeat (2) @(negedge clock);
        outs(gPin, qPin);
        host.access(1'b0, 8'h02, 16'h0000);
        chk("unmappedRead", regReadValid, 1'b0);
        chk("unmappedData", regReadData, 16'h0000);
        host.pins(1'b0, 1'b0);
        @(negedge clock) rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        resetCheck();
        final_report();
    end
endmodule // test_frontend_powerdown_control
